// ==== verilog/csf_pkg.sv ====
// constants, field layout and carriers of the codec slot data fifos
// Contract
// - connection field 00 off, 10 link
// - bit 3 picks single or paired stream
// - slot codes 3..11, 12 single only
// - paired mode serves slot and next, left first
// - starved slot request sets underflow, invalid word
// - underflow bit 15 sticky, write one clears
// - word into full receive fifo lost, overflow
// - overflow bit 15 sticky, write one clears
// - transmit level when words left equal mark
// - receive level once mark plus one words
// - bit 11 enables dma servicing
// - transmit full flag bit 13, read only
// - transmit empty flag read only, bit 14
// - receive full bit 13, empty bit 14
// - eight by sixteen, two each direction
// - data register per fifo, irq or dma
package csf_pkg;
    localparam int FIFO_W = 16;
    localparam int FIFO_D = 8;
    localparam int NUM_FIFO = 2;
    localparam int ADDR_W = 3;
    localparam int SLOT_W = 4;

    // control register fields
    localparam int CE_LO = 0;
    localparam int CE_HI = 1;
    localparam int PAIR_BIT = 3;
    localparam int SLOT_LO = 4;
    localparam int SLOT_HI = 7;
    localparam int MARK_LO = 8;
    localparam int MARK_HI = 10;
    localparam int DMA_BIT = 11;
    localparam int FULL_BIT = 13;
    localparam int EMPTY_BIT = 14;
    localparam int STICKY_BIT = 15;
    localparam logic [1:0] CE_OFF = 2'h0;
    localparam logic [1:0] CE_LINK = 2'h2;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    // bits 11:3 and 1:0 are stored; bit 2 and 12 read zero
    localparam logic [15:0] CTL_WR_MASK = 16'h0ffb;
    localparam logic [SLOT_W-1:0] SLOT_FIRST = 4'h3;
    localparam logic [SLOT_W-1:0] SLOT_PAIR_LAST = 4'hb;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 4'hc;

    // register indices on the peripheral register port
    localparam logic [ADDR_W-1:0] REG_TX0_CTL = 3'h0;
    localparam logic [ADDR_W-1:0] REG_TX0_DATA = 3'h1;
    localparam logic [ADDR_W-1:0] REG_TX1_CTL = 3'h2;
    localparam logic [ADDR_W-1:0] REG_TX1_DATA = 3'h3;
    localparam logic [ADDR_W-1:0] REG_RX0_CTL = 3'h4;
    localparam logic [ADDR_W-1:0] REG_RX0_DATA = 3'h5;
    localparam logic [ADDR_W-1:0] REG_RX1_CTL = 3'h6;
    localparam logic [ADDR_W-1:0] REG_RX1_DATA = 3'h7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [FIFO_W-1:0] wdata;
    } csf_reg_req_t;

    typedef struct packed {
        logic valid;
        logic [SLOT_W-1:0] slot;
    } csf_slot_req_t;

    typedef struct packed {
        logic valid;
        logic [SLOT_W-1:0] slot;
        logic [FIFO_W-1:0] data;
    } csf_rx_word_t;

    typedef struct packed {
        logic ans;
        logic ok;
        logic [FIFO_W-1:0] data;
    } csf_tx_ans_t;

    typedef struct packed {
        logic [NUM_FIFO-1:0][FIFO_W-1:0] tx_ctl;
        logic [NUM_FIFO-1:0][FIFO_W-1:0] rx_ctl;
        logic [NUM_FIFO-1:0] tx_under;
        logic [NUM_FIFO-1:0] rx_over;
        logic [FIFO_W-1:0] rdata;
        csf_tx_ans_t tx_ans;
        logic [NUM_FIFO-1:0] tx_irq;
        logic [NUM_FIFO-1:0] rx_irq;
        logic [NUM_FIFO-1:0] tx_dma;
        logic [NUM_FIFO-1:0] rx_dma;
        logic [NUM_FIFO-1:0] tx_rdy;
        logic [NUM_FIFO-1:0] rx_rdy;
    } csf_state_t;
endpackage

// ==== verilog/csf_fifo.sv ====
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module csf_fifo
    import csf_pkg::*;
#(
    parameter int WIDTH = FIFO_W,
    parameter int DEPTH = FIFO_D
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // level
    output logic [$clog2(DEPTH+1)-1:0] count,
    output logic full,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
    } csf_fifo_state_t;

    csf_fifo_state_t st_ff;
    csf_fifo_state_t nxt_st;
    logic push;
    logic pop;

    assign full = (st_ff.cnt == CNT_FULL);
    assign empty = (st_ff.cnt == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = st_ff.mem[st_ff.rd];
    assign count = st_ff.cnt;
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;

    always_comb
    begin
        nxt_st = st_ff;
        if (push)
        begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = (st_ff.wr == LAST) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop)
        begin
            nxt_st.rd = (st_ff.rd == LAST) ? '0 : st_ff.rd + 1'b1;
        end
        if (push && !pop)
        begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule

// ==== verilog/csf_slot_fifo.sv ====
// codec slot data fifos: two transmit and two receive, with control registers
`timescale 1ns/1ps
module csf_slot_fifo
    import csf_pkg::*;
#(
    parameter int DEPTH = FIFO_D
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // peripheral register port
    input wire csf_reg_req_t pr_req,
    output logic [FIFO_W-1:0] pr_rdata,
    output logic [NUM_FIFO-1:0] pr_tx_ready,
    // core service requests
    output logic [NUM_FIFO-1:0] tx_irq,
    output logic [NUM_FIFO-1:0] rx_irq,
    output logic [NUM_FIFO-1:0] tx_dma_req,
    output logic [NUM_FIFO-1:0] rx_dma_req,
    // link transmit slot request and answer
    input wire csf_slot_req_t lk_tx_req,
    output csf_tx_ans_t lk_tx_ans,
    // link receive slot words
    input wire csf_rx_word_t lk_rx_word,
    output logic [NUM_FIFO-1:0] lk_rx_ready
);
    localparam int CW = $clog2(DEPTH+1);

    // a slot belongs to this fifo only while linked and on a legal code
    function automatic logic slot_hit(input logic [FIFO_W-1:0] ctl,
                                      input logic [SLOT_W-1:0] slot);
        logic [SLOT_W-1:0] base;
        logic hit;
        base = ctl[SLOT_HI:SLOT_LO];
        hit = 1'b0;
        if (ctl[CE_HI:CE_LO] == CE_LINK)
        begin
            if (ctl[PAIR_BIT])
            begin
                hit = (base >= SLOT_FIRST) && (base <= SLOT_PAIR_LAST)
                      && ((slot == base) || (slot == base + 4'h1));
            end
            else
            begin
                hit = (base >= SLOT_FIRST) && (base <= SLOT_LAST)
                      && (slot == base);
            end
        end
        return hit;
    endfunction

    function automatic logic [FIFO_W-1:0] ctl_view(input logic [FIFO_W-1:0] ctl,
                                                 input logic sticky,
                                                 input logic empty,
                                                 input logic full);
        logic [FIFO_W-1:0] v;
        v = ctl & CTL_WR_MASK;
        v[STICKY_BIT] = sticky;
        v[EMPTY_BIT] = empty;
        v[FULL_BIT] = full;
        return v;
    endfunction

    csf_state_t st_ff;
    csf_state_t nxt_st;

    logic [NUM_FIFO-1:0] txf_push;
    logic [NUM_FIFO-1:0] txf_pop;
    logic [NUM_FIFO-1:0] txf_full;
    logic [NUM_FIFO-1:0] txf_empty;
    logic [NUM_FIFO-1:0][FIFO_W-1:0] txf_data;
    logic [NUM_FIFO-1:0][CW-1:0] txf_cnt;
    logic [NUM_FIFO-1:0] rxf_push;
    logic [NUM_FIFO-1:0] rxf_pop;
    logic [NUM_FIFO-1:0] rxf_full;
    logic [NUM_FIFO-1:0] rxf_empty;
    logic [NUM_FIFO-1:0][FIFO_W-1:0] rxf_data;
    logic [NUM_FIFO-1:0][CW-1:0] rxf_cnt;

    // eight words of sixteen bits per fifo, two in each direction
    genvar g;
    generate
        for (g = 0; g < NUM_FIFO; g++)
        begin : gen_fifo
            csf_fifo #(.WIDTH(FIFO_W), .DEPTH(DEPTH)) u_tx (
                .clk(clk),
                .rst(rst),
                .in_valid(txf_push[g]),
                .in_ready(),
                .in_data(pr_req.wdata),
                .out_valid(),
                .out_ready(txf_pop[g]),
                .out_data(txf_data[g]),
                .count(txf_cnt[g]),
                .full(txf_full[g]),
                .empty(txf_empty[g])
            );
            csf_fifo #(.WIDTH(FIFO_W), .DEPTH(DEPTH)) u_rx (
                .clk(clk),
                .rst(rst),
                .in_valid(rxf_push[g]),
                .in_ready(),
                .in_data(lk_rx_word.data),
                .out_valid(),
                .out_ready(rxf_pop[g]),
                .out_data(rxf_data[g]),
                .count(rxf_cnt[g]),
                .full(rxf_full[g]),
                .empty(rxf_empty[g])
            );
        end
    endgenerate

    always_comb
    begin
        logic found;
        logic lvl;
        logic [CW-1:0] mark;
        logic [ADDR_W-1:0] tx_ctl_a;
        logic [ADDR_W-1:0] tx_dat_a;
        logic [ADDR_W-1:0] rx_ctl_a;
        logic [ADDR_W-1:0] rx_dat_a;
        found = 1'b0;
        lvl = 1'b0;
        mark = '0;
        tx_ctl_a = '0;
        tx_dat_a = '0;
        rx_ctl_a = '0;
        rx_dat_a = '0;
        nxt_st = st_ff;
        nxt_st.tx_ans = '0;
        txf_push = '0;
        txf_pop = '0;
        rxf_push = '0;
        rxf_pop = '0;
        if (pr_req.rd)
        begin
            nxt_st.rdata = '0;
        end
        for (int i = 0; i < NUM_FIFO; i++)
        begin
            tx_ctl_a = (i == 0) ? REG_TX0_CTL : REG_TX1_CTL;
            tx_dat_a = (i == 0) ? REG_TX0_DATA : REG_TX1_DATA;
            rx_ctl_a = (i == 0) ? REG_RX0_CTL : REG_RX1_CTL;
            rx_dat_a = (i == 0) ? REG_RX0_DATA : REG_RX1_DATA;

            // register writes; reserved bit 2 and read-only flags are dropped
            if (pr_req.wr && pr_req.addr == tx_ctl_a)
            begin
                nxt_st.tx_ctl[i] = pr_req.wdata & CTL_WR_MASK;
                if (pr_req.wdata[STICKY_BIT])
                begin
                    nxt_st.tx_under[i] = 1'b0;
                end
            end
            if (pr_req.wr && pr_req.addr == rx_ctl_a)
            begin
                nxt_st.rx_ctl[i] = pr_req.wdata & CTL_WR_MASK;
                if (pr_req.wdata[STICKY_BIT])
                begin
                    nxt_st.rx_over[i] = 1'b0;
                end
            end
            // a write to a full transmit fifo is dropped; software checks ready
            txf_push[i] = pr_req.wr && (pr_req.addr == tx_dat_a) && !txf_full[i];
            rxf_pop[i] = pr_req.rd && (pr_req.addr == rx_dat_a);

            if (pr_req.rd && pr_req.addr == tx_ctl_a)
            begin
                nxt_st.rdata = ctl_view(st_ff.tx_ctl[i], st_ff.tx_under[i],
                                        txf_empty[i], txf_full[i]);
            end
            if (pr_req.rd && pr_req.addr == rx_ctl_a)
            begin
                nxt_st.rdata = ctl_view(st_ff.rx_ctl[i], st_ff.rx_over[i],
                                        rxf_empty[i], rxf_full[i]);
            end
            if (pr_req.rd && pr_req.addr == rx_dat_a)
            begin
                nxt_st.rdata = rxf_empty[i] ? '0 : rxf_data[i];
            end

            // transmit slot request: lowest matching fifo answers
            if (lk_tx_req.valid && !found && slot_hit(st_ff.tx_ctl[i], lk_tx_req.slot))
            begin
                found = 1'b1;
                nxt_st.tx_ans.ans = 1'b1;
                if (txf_empty[i])
                begin
                    nxt_st.tx_under[i] = 1'b1;
                end
                else
                begin
                    txf_pop[i] = 1'b1;
                    nxt_st.tx_ans.ok = 1'b1;
                    nxt_st.tx_ans.data = txf_data[i];
                end
            end

            // receive slot word; a full fifo loses it
            if (lk_rx_word.valid && slot_hit(st_ff.rx_ctl[i], lk_rx_word.slot))
            begin
                if (rxf_full[i] && !rxf_pop[i])
                begin
                    nxt_st.rx_over[i] = 1'b1;
                end
                else
                begin
                    rxf_push[i] = !rxf_full[i];
                    // a word meeting a read of the full fifo still cannot fit this cycle
                    nxt_st.rx_over[i] = st_ff.rx_over[i] || rxf_full[i];
                    if (pr_req.wr && pr_req.addr == rx_ctl_a && pr_req.wdata[STICKY_BIT]
                        && !rxf_full[i])
                    begin
                        nxt_st.rx_over[i] = 1'b0;
                    end
                end
            end

            // level conditions go to interrupt or dma by the enable bit
            mark = CW'(st_ff.tx_ctl[i][MARK_HI:MARK_LO]);
            lvl = (txf_cnt[i] == mark);
            nxt_st.tx_irq[i] = lvl && !st_ff.tx_ctl[i][DMA_BIT];
            nxt_st.tx_dma[i] = lvl && st_ff.tx_ctl[i][DMA_BIT];
            mark = CW'(st_ff.rx_ctl[i][MARK_HI:MARK_LO]) + CW'(1);
            lvl = (rxf_cnt[i] >= mark);
            nxt_st.rx_irq[i] = lvl && !st_ff.rx_ctl[i][DMA_BIT];
            nxt_st.rx_dma[i] = lvl && st_ff.rx_ctl[i][DMA_BIT];
            nxt_st.tx_rdy[i] = !txf_full[i];
            nxt_st.rx_rdy[i] = !rxf_full[i];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff <= '{tx_ctl: {NUM_FIFO{CTL_RESET}}, rx_ctl: {NUM_FIFO{CTL_RESET}},
                       default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign pr_rdata = st_ff.rdata;
    assign pr_tx_ready = st_ff.tx_rdy;
    assign tx_irq = st_ff.tx_irq;
    assign rx_irq = st_ff.rx_irq;
    assign tx_dma_req = st_ff.tx_dma;
    assign rx_dma_req = st_ff.rx_dma;
    assign lk_tx_ans = st_ff.tx_ans;
    assign lk_rx_ready = st_ff.rx_rdy;
endmodule

// ==== tb/csf_slot_fifo_sva.sv ====
// port assertions for the codec slot data fifos
`timescale 1ns/1ps
module csf_slot_fifo_chk
    import csf_pkg::*;
#(
    parameter int DEPTH = FIFO_D
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire csf_reg_req_t pr_req,
    input wire logic [FIFO_W-1:0] pr_rdata,
    input wire logic [NUM_FIFO-1:0] pr_tx_ready,
    // service requests
    input wire logic [NUM_FIFO-1:0] tx_irq,
    input wire logic [NUM_FIFO-1:0] rx_irq,
    input wire logic [NUM_FIFO-1:0] tx_dma_req,
    input wire logic [NUM_FIFO-1:0] rx_dma_req,
    // link side
    input wire csf_slot_req_t lk_tx_req,
    input wire csf_tx_ans_t lk_tx_ans,
    input wire csf_rx_word_t lk_rx_word,
    input wire logic [NUM_FIFO-1:0] lk_rx_ready
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_ans_req;
        lk_tx_ans.ans |-> $past(lk_tx_req.valid);
    endproperty
    a_ans_req: assert property (p_ans_req)
        else $error("answer without a slot request");

    property p_bad_slot;
        lk_tx_req.valid && (lk_tx_req.slot < SLOT_FIRST || lk_tx_req.slot > SLOT_LAST)
            |=> !lk_tx_ans.ans;
    endproperty
    a_bad_slot: assert property (p_bad_slot)
        else $error("reserved slot answered");

    property p_tx_route;
        (tx_irq & tx_dma_req) == '0;
    endproperty
    a_tx_route: assert property (p_tx_route)
        else $error("tx irq and dma both raised");

    property p_rx_route;
        (rx_irq & rx_dma_req) == '0;
    endproperty
    a_rx_route: assert property (p_rx_route)
        else $error("rx irq and dma both raised");

    // ready and the full bit sample the same fill state when ready is steady
    property p_tx_full;
        pr_req.rd && pr_req.addr == REG_TX0_CTL ##1 $stable(pr_tx_ready[0])
            |-> pr_rdata[FULL_BIT] == !pr_tx_ready[0];
    endproperty
    a_tx_full: assert property (p_tx_full)
        else $error("tx full bit disagrees with ready");

    property p_rx_full;
        pr_req.rd && pr_req.addr == REG_RX0_CTL ##1 $stable(lk_rx_ready[0])
            |-> pr_rdata[FULL_BIT] == !lk_rx_ready[0];
    endproperty
    a_rx_full: assert property (p_rx_full)
        else $error("rx full bit disagrees with ready");

    property p_rdata_hold;
        !pr_req.rd |=> $stable(pr_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");

    property p_txdata_zero;
        pr_req.rd && pr_req.addr == REG_TX0_DATA |=> pr_rdata == '0;
    endproperty
    a_txdata_zero: assert property (p_txdata_zero)
        else $error("tx data register read nonzero");

    c_under: cover property (lk_tx_ans.ans && !lk_tx_ans.ok);
    c_tx_full: cover property (!pr_tx_ready[0] ##1 !pr_tx_ready[0]);
    c_rx_irq: cover property ($rose(rx_irq[0]));
endmodule

bind csf_slot_fifo csf_slot_fifo_chk #(.DEPTH(DEPTH)) u_chk (
    .clk(clk), .rst(rst), .pr_req(pr_req), .pr_rdata(pr_rdata),
    .pr_tx_ready(pr_tx_ready), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .lk_tx_req(lk_tx_req),
    .lk_tx_ans(lk_tx_ans), .lk_rx_word(lk_rx_word), .lk_rx_ready(lk_rx_ready)
);

// ==== tb/csf_link_model.sv ====
// link slot logic model: asks for transmit words, delivers receive words
`timescale 1ns/1ps
module csf_link_model
    import csf_pkg::*;
(
    // clock
    input wire logic clk,
    // link side of the fifos
    output csf_slot_req_t lk_tx_req,
    input wire csf_tx_ans_t lk_tx_ans,
    output csf_rx_word_t lk_rx_word
);
    initial
    begin
        lk_tx_req = '0;
        lk_rx_word = '0;
    end

    // a paired stream is asked left slot first, one locked codec only
    task automatic ask(input logic [SLOT_W-1:0] s, output logic g, output logic o,
                       output logic [FIFO_W-1:0] d);
        @(posedge clk);
        #1;
        lk_tx_req = {1'b1, s};
        @(posedge clk);
        #1;
        // released slot shows the inverse so a late sample cannot match
        lk_tx_req = {1'b0, ~s};
        g = lk_tx_ans.ans;
        o = lk_tx_ans.ok;
        d = lk_tx_ans.data;
    endtask

    task automatic send(input logic [SLOT_W-1:0] s, input logic [FIFO_W-1:0] d);
        @(posedge clk);
        #1;
        lk_rx_word = {1'b1, s, d};
        @(posedge clk);
        #1;
        lk_rx_word = {1'b0, ~s, ~d};
    endtask
endmodule

// ==== tb/csf_slot_fifo_tb.sv ====
// self-checking bench for the codec slot data fifos
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("Error %0t ns: got %h exp %h", $time, got, exp); \
        end \
    end
module csf_slot_fifo_tb
    import csf_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    csf_reg_req_t pr_req = '0;
    logic [FIFO_W-1:0] pr_rdata, rv, dv;
    logic [NUM_FIFO-1:0] pr_tx_ready, tx_irq, rx_irq, tx_dma_req, rx_dma_req, lk_rx_ready;
    csf_slot_req_t lk_tx_req;
    csf_tx_ans_t lk_tx_ans;
    csf_rx_word_t lk_rx_word;
    logic got, ok;
    int mismatches = 0;
    int total_checks = 0;

    always #50 clk = ~clk;

    csf_slot_fifo #(.DEPTH(FIFO_D)) uut (
        .clk(clk), .rst(rst), .pr_req(pr_req), .pr_rdata(pr_rdata),
        .pr_tx_ready(pr_tx_ready), .tx_irq(tx_irq), .rx_irq(rx_irq),
        .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .lk_tx_req(lk_tx_req),
        .lk_tx_ans(lk_tx_ans), .lk_rx_word(lk_rx_word), .lk_rx_ready(lk_rx_ready)
    );

    csf_link_model u_link (
        .clk(clk), .lk_tx_req(lk_tx_req), .lk_tx_ans(lk_tx_ans), .lk_rx_word(lk_rx_word)
    );

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [FIFO_W-1:0] d);
        @(posedge clk);
        #1;
        pr_req = {1'b1, 1'b0, a, d};
        @(posedge clk);
        #1;
        pr_req = {1'b0, 1'b0, ~a, ~d};
    endtask

    task automatic rc(input logic [ADDR_W-1:0] a, input logic [FIFO_W-1:0] e);
        @(posedge clk);
        #1;
        pr_req = {1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        #1;
        pr_req = {1'b0, 1'b0, ~a, 16'hffff};
        rv = pr_rdata;
        `CHK(rv, e)
    endtask

    task automatic ak(input logic [3:0] s, input logic eg, input logic eo,
                      input logic [FIFO_W-1:0] ed);
        u_link.ask(s, got, ok, dv);
        `CHK(got, eg)
        if (eg)
        begin
            `CHK(ok, eo)
        end
        if (eg && eo)
        begin
            `CHK(dv, ed)
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        results();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        rc(REG_TX0_CTL, 16'h4000);
        rc(REG_RX1_CTL, 16'h4000);
        rc(REG_TX0_DATA, 16'h0000);
        rc(REG_RX0_DATA, 16'h0000);
        ak(4'h3, 1'b0, 1'b0, 16'h0000);
        u_link.send(4'h3, 16'h1234);
        rc(REG_RX0_CTL, 16'h4000);
        wr(REG_TX1_CTL, 16'hfffb);
        rc(REG_TX1_CTL, 16'h4ffb);
        // single slot 3, mark 2, interrupt routing; bit 2 always written zero
        wr(REG_TX0_CTL, 16'h0232);
        for (int i = 0; i < 9; i++)
            wr(REG_TX0_DATA, 16'ha000 + 16'(i));
        rc(REG_TX0_CTL, 16'h2232);
        `CHK(pr_tx_ready[0], 1'b0)
        for (int i = 0; i < 8; i++)
        begin
            ak(4'h3, 1'b1, 1'b1, 16'ha000 + 16'(i));
            tick();
            `CHK(tx_irq[0], 1'(i == 5))
            `CHK(tx_dma_req[0], 1'b0)
        end
        ak(4'h4, 1'b0, 1'b0, 16'h0000);
        ak(4'h2, 1'b0, 1'b0, 16'h0000);
        ak(4'h3, 1'b1, 1'b0, 16'h0000);
        rc(REG_TX0_CTL, 16'hc232);
        wr(REG_TX0_CTL, 16'h0232);
        rc(REG_TX0_CTL, 16'hc232);
        wr(REG_TX0_CTL, 16'h8232);
        rc(REG_TX0_CTL, 16'h4232);
        // paired slots 11/12 served by dma at mark 0
        wr(REG_TX1_CTL, 16'h08ba);
        tick();
        `CHK(tx_dma_req[1], 1'b1)
        `CHK(tx_irq[1], 1'b0)
        wr(REG_TX1_DATA, 16'h1111);
        wr(REG_TX1_DATA, 16'h2222);
        rc(REG_TX1_CTL, 16'h08ba);
        `CHK(tx_dma_req[1], 1'b0)
        ak(4'hb, 1'b1, 1'b1, 16'h1111);
        ak(4'hc, 1'b1, 1'b1, 16'h2222);
        wr(REG_TX1_CTL, 16'h00ca);
        ak(4'hc, 1'b0, 1'b0, 16'h0000);
        // single slot 12 receive, mark 3, overrun on the ninth word
        wr(REG_RX0_CTL, 16'h03c2);
        for (int i = 0; i < 9; i++)
        begin
            u_link.send(4'hc, 16'hc000 + 16'(i));
            tick();
            `CHK(rx_irq[0], 1'(i >= 3))
        end
        `CHK(lk_rx_ready[0], 1'b0)
        rc(REG_RX0_CTL, 16'ha3c2);
        // clear while full and unplug: a word into the full fifo must not flag now
        wr(REG_RX0_CTL, 16'h83c0);
        u_link.send(4'hc, 16'h0bad);
        rc(REG_RX0_CTL, 16'h23c0);
        wr(REG_RX0_CTL, 16'h03c2);
        u_link.send(4'hc, 16'h0bad);
        rc(REG_RX0_CTL, 16'ha3c2);
        for (int i = 0; i < 8; i++)
            rc(REG_RX0_DATA, 16'hc000 + 16'(i));
        rc(REG_RX0_CTL, 16'hc3c2);
        wr(REG_RX0_CTL, 16'h83c2);
        rc(REG_RX0_CTL, 16'h43c2);
        // reserved connection code leaves the fifo off the link
        wr(REG_RX1_CTL, 16'h0059);
        u_link.send(4'h5, 16'h0bad);
        rc(REG_RX1_CTL, 16'h4059);
        wr(REG_RX1_CTL, 16'h085a);
        u_link.send(4'h5, 16'h5555);
        u_link.send(4'h6, 16'h6666);
        u_link.send(4'h7, 16'h7777);
        tick();
        `CHK(rx_dma_req[1], 1'b1)
        `CHK(rx_irq[1], 1'b0)
        rc(REG_RX1_DATA, 16'h5555);
        rc(REG_RX1_DATA, 16'h6666);
        rc(REG_RX1_CTL, 16'h485a);
        results();
    end
endmodule
